// [core/isr_pkg.sv]
// Package: constants and types of the instrument status reporting block
package isr_pkg;
  localparam int ISR_NUM_GROUPS = 5;
  localparam int ISR_GRP_W = 16;
  // Group indices
  localparam logic [2:0] ISR_GRP_STD = 3'h0;
  localparam logic [2:0] ISR_GRP_OPER = 3'h1;
  localparam logic [2:0] ISR_GRP_QUES = 3'h2;
  localparam logic [2:0] ISR_GRP_ALRM = 3'h3;
  localparam logic [2:0] ISR_GRP_SBYTE = 3'h4;
  // Status byte bit positions
  localparam int ISR_SB_ALRM = 1;
  localparam int ISR_SB_ERRQ = 2;
  localparam int ISR_SB_QUES = 3;
  localparam int ISR_SB_MAV = 4;
  localparam int ISR_SB_STD = 5;
  localparam int ISR_SB_MSS = 6;
  localparam int ISR_SB_OPER = 7;
  // Reset values
  localparam logic [15:0] ISR_ENA_RST = 16'h0000;
  localparam logic [7:0] ISR_SRE_RST = 8'h00;
  localparam logic ISR_PSC_RST = 1'b1;
  // Register selectors for a query
  typedef enum logic [1:0] {
    ISR_REG_COND = 2'h0,
    ISR_REG_EVENT = 2'h1,
    ISR_REG_ENABLE = 2'h3
  } isr_reg_type;
  // Scan control states, Gray along idle-run-stopped
  typedef enum logic [1:0] {
    ISR_SCAN_IDLE = 2'h0,
    ISR_SCAN_RUN = 2'h1,
    ISR_SCAN_STOP = 2'h3
  } isr_scan_type;
endpackage

// [core/isr_group.sv]
// One status register group: condition, latching event, enable, summary
`timescale 1ns/1ps
module isr_group
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Condition and control
  input wire logic [15:0] cond_i,
  input wire logic clr_event_i,
  input wire logic ena_wr_i,
  input wire logic [15:0] ena_wdata_i,
  input wire logic ena_clr_i,
  input wire logic ena_rst_clr_i,
  // State
  output logic [15:0] event_o,
  output logic [15:0] enable_o,
  output logic summary_o
);
  logic [15:0] cond_q_r;
  logic [15:0] event_r;
  logic [15:0] event_nxt;
  logic [15:0] enable_r;
  logic [15:0] enable_nxt;
  wire logic [15:0] rising = cond_i & ~cond_q_r;

  // Set wins over a clearing read in the same cycle
  assign event_nxt = clr_event_i ? rising : (event_r | rising);
  assign enable_nxt = ena_clr_i ? ISR_ENA_RST :
                      (ena_wr_i ? ena_wdata_i : enable_r);

  always_ff @(posedge CLK_I) begin
    cond_q_r <= cond_i;
    if (RESET_I) begin
      event_r <= 16'h0000;
    end else begin
      event_r <= event_nxt;
    end
    // Enable survives restart unless power-on clear is set
    if (RESET_I && ena_rst_clr_i) begin
      enable_r <= ISR_ENA_RST;
    end else if (!RESET_I) begin
      enable_r <= enable_nxt;
    end
  end

  assign event_o = event_r;
  assign enable_o = enable_r;
  assign summary_o = |(event_r & enable_r);
endmodule // isr_group

// [core/isr_top.sv]
// Instrument status reporting: groups, status byte, scan control
`timescale 1ns/1ps
module isr_top
  import isr_pkg::*;
(
  // Clock and reset (RESET_I is a restart)
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Instrument conditions, asynchronous to the clock
  input wire logic [15:0] STD_COND_I,
  input wire logic [15:0] OPER_COND_I,
  input wire logic [15:0] QUES_COND_I,
  input wire logic [15:0] ALRM_COND_I,
  input wire logic MSG_AVAIL_I,
  input wire logic ERR_QUEUE_NONEMPTY_I,
  // Decoded host commands, one-cycle pulses
  input wire logic CLS_I,
  input wire logic STAT_PRESET_I,
  input wire logic PSC_WR_I,
  input wire logic PSC_VAL_I,
  input wire logic SRE_WR_I,
  input wire logic [7:0] SRE_VAL_I,
  input wire logic ENA_WR_I,
  input wire logic [2:0] ENA_GRP_I,
  input wire logic [15:0] ENA_VAL_I,
  input wire logic QUERY_I,
  input wire logic [2:0] QUERY_GRP_I,
  input wire logic [1:0] QUERY_REG_I,
  input wire logic ABORT_I,
  input wire logic RST_CMD_I,
  input wire logic SYS_PRESET_I,
  input wire logic INIT_I,
  input wire logic SCAN_DONE_I,
  // Parameter snapping
  input wire logic [15:0] PARAM_VAL_I,
  input wire logic PARAM_UP_I,
  // Query answer
  output logic QUERY_VALID_O,
  output logic [15:0] QUERY_DATA_O,
  // Status byte
  output logic [7:0] STATUS_BYTE_O,
  output logic [7:0] SRE_O,
  output logic PSC_O,
  // Scan control and snapped parameter
  output logic SCAN_ACTIVE_O,
  output logic MEAS_ABORT_O,
  output logic CLR_READINGS_O,
  output logic CLR_SCAN_LIST_O,
  output logic FACTORY_RESTORE_O,
  output logic [15:0] PARAM_STD_O
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SYNC_W = 4 * ISR_GRP_W + 2;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge CLK_I) begin
    sync1_r <= {STD_COND_I, OPER_COND_I, QUES_COND_I, ALRM_COND_I,
                MSG_AVAIL_I, ERR_QUEUE_NONEMPTY_I};
    sync2_r <= sync1_r;
  end
  logic [15:0] cond [ISR_NUM_GROUPS];
  wire logic msg_avail = sync2_r[1];
  wire logic err_nonempty = sync2_r[0];
  assign cond[ISR_GRP_STD] = sync2_r[65:50];
  assign cond[ISR_GRP_OPER] = sync2_r[49:34];
  assign cond[ISR_GRP_QUES] = sync2_r[33:18];
  assign cond[ISR_GRP_ALRM] = sync2_r[17:2];

  ////////////////////////////////////////////////////////////////////////
  // Power-on clear setting, retained across restart
  logic psc_r;
  // Power-up value: the setting survives restart, so no reset can seed it
  logic psc_init_r = 1'b0;
  always_ff @(posedge CLK_I) begin
    if (!psc_init_r) begin
      psc_init_r <= 1'b1;
      psc_r <= ISR_PSC_RST;
    end else if (PSC_WR_I && !RESET_I) begin
      psc_r <= PSC_VAL_I;
    end
  end
  // First power-up always clears, like a restart with the setting at 1
  wire logic ena_rst_clr = psc_r | ~psc_init_r;

  ////////////////////////////////////////////////////////////////////////
  // Register groups
  function automatic logic query_hits(input logic [2:0] g,
                                      input logic [1:0] r);
    query_hits = QUERY_I && QUERY_GRP_I == g && r == ISR_REG_EVENT;
  endfunction

  logic [15:0] evt [ISR_NUM_GROUPS];
  logic [15:0] ena [ISR_NUM_GROUPS];
  logic [ISR_NUM_GROUPS-1:0] summ;
  genvar gi;
  generate
    for (gi = 0; gi < ISR_NUM_GROUPS - 1; gi++) begin : g_grp
      isr_group u_grp (
        .CLK_I(CLK_I),
        .RESET_I(RESET_I),
        .cond_i(cond[gi]),
        .clr_event_i(CLS_I | query_hits(3'(gi), QUERY_REG_I)),
        .ena_wr_i(ENA_WR_I && ENA_GRP_I == 3'(gi)),
        .ena_wdata_i(ENA_VAL_I),
        .ena_clr_i(STAT_PRESET_I),
        .ena_rst_clr_i(ena_rst_clr),
        .event_o(evt[gi]),
        .enable_o(ena[gi]),
        .summary_o(summ[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status byte: live summaries, so clearing a group clears its bit
  logic [7:0] sb_cond;
  assign sb_cond[0] = 1'b0;
  assign sb_cond[ISR_SB_ALRM] = summ[ISR_GRP_ALRM];
  assign sb_cond[ISR_SB_ERRQ] = err_nonempty;
  assign sb_cond[ISR_SB_QUES] = summ[ISR_GRP_QUES];
  assign sb_cond[ISR_SB_MAV] = msg_avail;
  assign sb_cond[ISR_SB_STD] = summ[ISR_GRP_STD];
  assign sb_cond[ISR_SB_OPER] = summ[ISR_GRP_OPER];
  // Master summary over the other bits; CLS clears the group sources, not MAV or the error-queue bit
  assign sb_cond[ISR_SB_MSS] = |{sb_cond[7], sb_cond[5:0]};

  logic [7:0] sb_r;
  logic [7:0] sre_r;
  logic [7:0] sre_nxt;
  assign sre_nxt = SRE_WR_I ? SRE_VAL_I : sre_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sb_r <= 8'h00;
    end else begin
      sb_r <= sb_cond;
    end
    if (RESET_I && ena_rst_clr) begin
      sre_r <= ISR_SRE_RST;
    end else if (!RESET_I) begin
      sre_r <= sre_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Query path: value returned as a binary word, bit n of weight 2^n
  logic [15:0] grp_cond;
  logic [15:0] grp_evt;
  logic [15:0] grp_ena;
  wire logic is_sb = QUERY_GRP_I == ISR_GRP_SBYTE;
  wire logic grp_ok = QUERY_GRP_I < 3'(ISR_NUM_GROUPS);
  assign grp_cond = is_sb ? {8'h00, sb_r} :
                    (grp_ok ? cond[QUERY_GRP_I] : 16'h0000);
  assign grp_evt = (is_sb || !grp_ok) ? 16'h0000 : evt[QUERY_GRP_I];
  assign grp_ena = is_sb ? {8'h00, sre_r} :
                   (grp_ok ? ena[QUERY_GRP_I] : 16'h0000);
  logic [15:0] query_sel;
  assign query_sel = QUERY_REG_I == ISR_REG_COND ? grp_cond :
                     (QUERY_REG_I == ISR_REG_EVENT ? grp_evt : grp_ena);
  logic q_valid_r;
  logic [15:0] q_data_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      q_valid_r <= 1'b0;
      q_data_r <= 16'h0000;
    end else begin
      q_valid_r <= QUERY_I;
      if (QUERY_I) begin
        q_data_r <= query_sel;
      end
    end
  end
  // Only the tail group slot is spare; tie its summary low
  assign summ[ISR_GRP_SBYTE] = 1'b0;
  assign evt[ISR_GRP_SBYTE] = 16'h0000;
  assign ena[ISR_GRP_SBYTE] = 16'h0000;
  assign cond[ISR_GRP_SBYTE] = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Scan control
  isr_scan_type scan_r;
  isr_scan_type scan_nxt;
  wire logic stop_cmd = ABORT_I | RST_CMD_I | SYS_PRESET_I;
  always_comb begin
    scan_nxt = scan_r;
    unique case (scan_r)
      ISR_SCAN_IDLE: begin
        if (INIT_I && !stop_cmd) begin
          scan_nxt = ISR_SCAN_RUN;
        end
      end
      ISR_SCAN_RUN: begin
        if (stop_cmd) begin
          scan_nxt = ISR_SCAN_STOP;
        end else if (SCAN_DONE_I) begin
          scan_nxt = ISR_SCAN_IDLE;
        end
      end
      ISR_SCAN_STOP: begin
        // No resume: only a fresh initiate restarts
        if (INIT_I && !stop_cmd) begin
          scan_nxt = ISR_SCAN_RUN;
        end
      end
      default: scan_nxt = ISR_SCAN_IDLE;
    endcase
  end
  logic abort_r;
  logic clr_rd_r;
  logic clr_list_r;
  logic factory_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      scan_r <= ISR_SCAN_IDLE;
      abort_r <= 1'b0;
      clr_rd_r <= 1'b0;
      clr_list_r <= 1'b0;
      factory_r <= 1'b0;
    end else begin
      scan_r <= scan_nxt;
      abort_r <= stop_cmd;
      clr_rd_r <= INIT_I && !stop_cmd;
      clr_list_r <= RST_CMD_I;
      factory_r <= RST_CMD_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameter snapping to standard values (powers of two as the ladder)
  function automatic logic [15:0] snap(input logic [15:0] v,
                                       input logic up);
    logic [15:0] lo;
    lo = 16'h0001;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        lo = 16'h0001 << i;
      end
    end
    if (v == lo || !up) begin
      snap = lo;
    end else begin
      snap = (lo == 16'h8000) ? lo : 16'(lo << 1);
    end
  endfunction
  logic [15:0] param_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      param_r <= 16'h0001;
    end else begin
      param_r <= snap(PARAM_VAL_I, PARAM_UP_I);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign QUERY_VALID_O = q_valid_r;
  assign QUERY_DATA_O = q_data_r;
  assign STATUS_BYTE_O = sb_r;
  assign SRE_O = sre_r;
  assign PSC_O = psc_r;
  assign SCAN_ACTIVE_O = scan_r == ISR_SCAN_RUN;
  assign MEAS_ABORT_O = abort_r;
  assign CLR_READINGS_O = clr_rd_r;
  assign CLR_SCAN_LIST_O = clr_list_r;
  assign FACTORY_RESTORE_O = factory_r;
  assign PARAM_STD_O = param_r;
endmodule // isr_top

// [tb/isr_assertions.sv]
// Checker: port-level assertions of the status reporting block
`timescale 1ns/1ps
module isr_checker (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Watched inputs
  input wire logic MSG_AVAIL_I,
  input wire logic ERR_QUEUE_NONEMPTY_I,
  input wire logic CLS_I,
  input wire logic PSC_WR_I,
  input wire logic PSC_VAL_I,
  input wire logic SRE_WR_I,
  input wire logic [7:0] SRE_VAL_I,
  input wire logic QUERY_I,
  input wire logic ABORT_I,
  input wire logic RST_CMD_I,
  // Watched outputs
  input wire logic QUERY_VALID_O,
  input wire logic [7:0] STATUS_BYTE_O,
  input wire logic [7:0] SRE_O,
  input wire logic PSC_O,
  input wire logic SCAN_ACTIVE_O,
  input wire logic MEAS_ABORT_O,
  input wire logic CLR_SCAN_LIST_O,
  input wire logic FACTORY_RESTORE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Levels cross two sync flops, so five steady samples are plenty
  sequence s_mav; (MSG_AVAIL_I && !CLS_I)[*5]; endsequence
  sequence s_err; (ERR_QUEUE_NONEMPTY_I && !CLS_I)[*5]; endsequence
  property p_bit0; STATUS_BYTE_O[0] == 1'b0; endproperty
  property p_master;
    STATUS_BYTE_O[6] == |{STATUS_BYTE_O[7], STATUS_BYTE_O[5:1]};
  endproperty
  property p_query; QUERY_I |=> QUERY_VALID_O; endproperty
  property p_mav; s_mav |-> STATUS_BYTE_O[4]; endproperty
  property p_err; s_err |-> STATUS_BYTE_O[2]; endproperty
  property p_sre; SRE_WR_I |=> SRE_O == $past(SRE_VAL_I); endproperty
  property p_psc; PSC_WR_I |=> PSC_O == $past(PSC_VAL_I); endproperty
  property p_abort; ABORT_I |=> MEAS_ABORT_O && !SCAN_ACTIVE_O; endproperty
  property p_rst;
    RST_CMD_I |=> MEAS_ABORT_O && CLR_SCAN_LIST_O && FACTORY_RESTORE_O;
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit 0 set");
  a_master: assert property (p_master) else $error("bad master");
  a_query: assert property (p_query) else $error("no answer");
  a_mav: assert property (p_mav) else $error("bit 4 low");
  a_err: assert property (p_err) else $error("bit 2 low");
  a_sre: assert property (p_sre) else $error("bad byte enable");
  a_psc: assert property (p_psc) else $error("bad clear setting");
  a_abort: assert property (p_abort) else $error("abort missed");
  a_rst: assert property (p_rst) else $error("reset cmd missed");
endmodule // isr_checker
////////////////////////////////////////
bind isr_top isr_checker isr_checker_i (.CLK_I, .RESET_I, .MSG_AVAIL_I,
  .ERR_QUEUE_NONEMPTY_I, .CLS_I, .PSC_WR_I, .PSC_VAL_I, .SRE_WR_I,
  .SRE_VAL_I, .QUERY_I, .ABORT_I, .RST_CMD_I, .QUERY_VALID_O,
  .STATUS_BYTE_O, .SRE_O, .PSC_O, .SCAN_ACTIVE_O, .MEAS_ABORT_O,
  .CLR_SCAN_LIST_O, .FACTORY_RESTORE_O);

// [tb/isr_host.sv]
// Host model: issues register queries and takes the answers
`timescale 1ns/1ps
module isr_host (
  // Clock
  input wire logic clk_i,
  // Answer from the block
  input wire logic valid_i,
  input wire logic [15:0] data_i,
  // Query request
  output logic query_o,
  output logic [2:0] grp_o,
  output logic [1:0] reg_o
);
  initial begin
    query_o = 1'b0;
    grp_o = 3'h0;
    reg_o = 2'h0;
  end
  // Answer is taken one cycle on; a missing answer reads as unknown
  task automatic query(logic [2:0] g, logic [1:0] r, output logic [15:0] d);
    @(negedge clk_i);
    query_o = 1'b1;
    grp_o = g;
    reg_o = r;
    @(negedge clk_i);
    query_o = 1'b0;
    grp_o = ~g;
    reg_o = ~r;
    d = (valid_i === 1'b1) ? data_i : 16'hXXXX;
  endtask
endmodule // isr_host

// [tb/instrument_status_reporting_test.sv]
// Testbench: random and corner stimulus for the status reporting block
`timescale 1ns/1ps
module instrument_status_reporting_test
  import isr_pkg::*;
;
  logic CLK_I = 1'b0, RESET_I = 1'b1, MSG_AVAIL_I = 1'b0, CLS_I = 1'b0;
  logic ERR_QUEUE_NONEMPTY_I = 1'b0, STAT_PRESET_I = 1'b0, INIT_I = 1'b0;
  logic PSC_WR_I = 1'b0, PSC_VAL_I = 1'b0, SRE_WR_I = 1'b0, ENA_WR_I = 1'b0;
  logic ABORT_I = 1'b0, RST_CMD_I = 1'b0, SYS_PRESET_I = 1'b0;
  logic SCAN_DONE_I = 1'b0, PARAM_UP_I = 1'b0, QUERY_I, QUERY_VALID_O;
  logic [15:0] STD_COND_I, OPER_COND_I, QUES_COND_I, ALRM_COND_I;
  logic [15:0] ENA_VAL_I = '0, PARAM_VAL_I = 16'h0001;
  logic [15:0] QUERY_DATA_O, PARAM_STD_O, cond[4] = '{default: '0};
  logic [7:0] SRE_VAL_I = '0, STATUS_BYTE_O, SRE_O;
  logic [2:0] ENA_GRP_I = '0, QUERY_GRP_I;
  logic [1:0] QUERY_REG_I;
  logic PSC_O, SCAN_ACTIVE_O, MEAS_ABORT_O, CLR_READINGS_O;
  logic CLR_SCAN_LIST_O, FACTORY_RESTORE_O;
  int n_mismatch = 0, num_checks = 0;
  int pos[4] = '{ISR_SB_STD, ISR_SB_OPER, ISR_SB_QUES, ISR_SB_ALRM};
  assign {ALRM_COND_I, QUES_COND_I, OPER_COND_I, STD_COND_I} =
    {cond[3], cond[2], cond[1], cond[0]};
  isr_top isr_top_i (.*);
  isr_host isr_host_i (.clk_i(CLK_I), .valid_i(QUERY_VALID_O),
    .data_i(QUERY_DATA_O), .query_o(QUERY_I), .grp_o(QUERY_GRP_I),
    .reg_o(QUERY_REG_I));
  ////////////////////////////////////////
  function automatic logic [15:0] snap(logic [15:0] v, logic up);
    logic [15:0] p = 16'h8000;
    while (p > v) p = p >> 1;
    return (up && p != v) ? p << 1 : p;
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK_I);
    s = 1'b1;
    @(negedge CLK_I);
    s = 1'b0;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge CLK_I);
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    forever #12.5 CLK_I = ~CLK_I;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge CLK_I);
    n_mismatch++;
    summarize;
  end
  initial begin
    logic [15:0] ena, cnd, d, v;
    logic [7:0] b;
    void'($urandom(32'h4DBF214B));
    cyc(3);
    RESET_I = 1'b0;
    chk("byte enable", SRE_O, 16'h0000);
    for (int g = 0; g < 4; g++) begin
      cnd = 16'($urandom) | 16'h0001;
      // First group: enables miss every event, so no summary
      ena = (g == 0) ? ~cnd : 16'($urandom);
      ENA_GRP_I = 3'(g);
      ENA_VAL_I = ena;
      pulse(ENA_WR_I);
      cond[g] = cnd;
      cyc(6);
      b = 8'h00;
      b[pos[g]] = |(cnd & ena);
      b[ISR_SB_MSS] = |b;
      chk("status byte", 16'(STATUS_BYTE_O), 16'(b));
      isr_host_i.query(3'(g), ISR_REG_ENABLE, d);
      chk("enable", d, ena);
      repeat (2) begin
        isr_host_i.query(3'(g), ISR_REG_COND, d);
        chk("condition", d, cnd);
      end
      isr_host_i.query(3'(g), ISR_REG_EVENT, d);
      chk("event", d, cnd);
      cyc(1);
      chk("status byte", 16'(STATUS_BYTE_O), 16'h0000);
      isr_host_i.query(3'(g), ISR_REG_EVENT, d);
      chk("event", d, 16'h0000);
      cond[g] = 16'h0000;
      cyc(4);
      cond[g] = cnd;
      cyc(6);
      pulse(CLS_I);
      cyc(2);
      chk("status byte", 16'(STATUS_BYTE_O), 16'h0000);
      isr_host_i.query(3'(g), ISR_REG_EVENT, d);
      chk("event", d, 16'h0000);
      cond[g] = 16'h0000;
    end
    MSG_AVAIL_I = 1'b1;
    cyc(5);
    chk("status byte", 16'(STATUS_BYTE_O), 16'h0050);
    isr_host_i.query(ISR_GRP_SBYTE, ISR_REG_COND, d);
    chk("byte query", d, 16'h0050);
    MSG_AVAIL_I = 1'b0;
    ERR_QUEUE_NONEMPTY_I = 1'b1;
    cyc(5);
    chk("status byte", 16'(STATUS_BYTE_O), 16'h0044);
    ERR_QUEUE_NONEMPTY_I = 1'b0;
    cyc(5);
    chk("status byte", 16'(STATUS_BYTE_O), 16'h0000);
    ENA_GRP_I = ISR_GRP_QUES;
    ENA_VAL_I = 16'hFFFF;
    pulse(ENA_WR_I);
    pulse(STAT_PRESET_I);
    isr_host_i.query(ISR_GRP_QUES, ISR_REG_ENABLE, d);
    chk("enable", d, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      v = 16'($urandom) | 16'h0001;
      PSC_VAL_I = p[0];
      pulse(PSC_WR_I);
      chk("clear setting", 16'(PSC_O), 16'(p));
      SRE_VAL_I = v[7:0];
      pulse(SRE_WR_I);
      ENA_VAL_I = v;
      pulse(ENA_WR_I);
      RESET_I = 1'b1;
      cyc(3);
      RESET_I = 1'b0;
      chk("byte enable", 16'(SRE_O), p ? 16'h0000 : 16'(v[7:0]));
      isr_host_i.query(ISR_GRP_QUES, ISR_REG_ENABLE, d);
      chk("enable", d, p ? 16'h0000 : v);
    end
    SRE_VAL_I = 8'hFF;
    pulse(SRE_WR_I);
    SRE_VAL_I = 8'h00;
    pulse(SRE_WR_I);
    chk("byte enable", 16'(SRE_O), 16'h0000);
    pulse(INIT_I);
    chk("readings clear", 16'(CLR_READINGS_O), 16'h0001);
    chk("scan active", 16'(SCAN_ACTIVE_O), 16'h0001);
    pulse(ABORT_I);
    chk("scan active", 16'(SCAN_ACTIVE_O), 16'h0000);
    pulse(INIT_I);
    pulse(SYS_PRESET_I);
    chk("abort", 16'(MEAS_ABORT_O), 16'h0001);
    chk("list clear", 16'(CLR_SCAN_LIST_O), 16'h0000);
    pulse(RST_CMD_I);
    chk("factory", 16'(FACTORY_RESTORE_O), 16'h0001);
    pulse(INIT_I);
    pulse(SCAN_DONE_I);
    chk("scan active", 16'(SCAN_ACTIVE_O), 16'h0000);
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? 16'h0400 : 16'($urandom_range(32'h7FFE)) + 16'h0001;
      PARAM_VAL_I = v;
      PARAM_UP_I = i[0];
      cyc(2);
      chk("snapped", PARAM_STD_O, snap(v, i[0]));
    end
    summarize;
  end
endmodule // instrument_status_reporting_test
